// File: hdl/sfcf_pkg.sv
// shared constants, types and opcode decode for the serial flash command front end
package sfcf_pkg;
  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int BYTE_W = 8;
  localparam int LINK_AW = 24; // address bits carried on the link
  localparam int ARRAY_AW = 21; // address bits the array decodes
  localparam logic [1:0] ADDR_LAST = 2'h2; // index of the third address byte
  localparam logic [2:0] ADDR_HDR = 3'h3; // address bytes in a header
  localparam logic [2:0] STEP_ONE = 3'h1; // bits per clock, single lane
  localparam logic [2:0] STEP_TWO = 3'h2; // bits per clock, dual lane

  // ****************************************************************
  // data phase kinds, states and decoded opcode
  // ****************************************************************
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_IN = 3'h1,
    K_OUT = 3'h2,
    K_DIN = 3'h3,
    K_DOUT = 3'h4
  } sfcf_kind_e;

  typedef struct packed {
    logic valid;
    logic has_addr;
    logic [1:0] dummy;
    sfcf_kind_e kind;
  } sfcf_op_s;

  typedef enum logic [5:0] {
    DS_OPC = 6'h01,
    DS_ADDR = 6'h02,
    DS_DUMMY = 6'h04,
    DS_DIN = 6'h08,
    DS_DOUT = 6'h10,
    DS_IGNORE = 6'h20
  } sfcf_dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_RUN = 3'h2,
    HS_GAP = 3'h4
  } sfcf_host_state_e;

  function automatic sfcf_op_s sfcf_mk(input logic a, input logic [1:0] d, input sfcf_kind_e k);
    sfcf_op_s r;
    r = '{valid: 1'b1, has_addr: a, dummy: d, kind: k};
    return r;
  endfunction

  // supported opcodes; anything else decodes as not valid
  function automatic sfcf_op_s sfcf_decode(input logic [BYTE_W-1:0] op);
    sfcf_op_s r;
    r = '{valid: 1'b0, has_addr: 1'b0, dummy: 2'h0, kind: K_NONE};
    case (op)
      8'h1B, 8'h77: r = sfcf_mk(1'b1, 2'h2, K_OUT);
      8'h0B: r = sfcf_mk(1'b1, 2'h1, K_OUT);
      8'h03, 8'h3C, 8'h35: r = sfcf_mk(1'b1, 2'h0, K_OUT);
      8'h3B: r = sfcf_mk(1'b1, 2'h1, K_DOUT);
      8'h20, 8'h52, 8'hD8, 8'h36, 8'h39: r = sfcf_mk(1'b1, 2'h0, K_NONE);
      8'h02, 8'h33, 8'h34, 8'h9B: r = sfcf_mk(1'b1, 2'h0, K_IN);
      8'hA2: r = sfcf_mk(1'b1, 2'h0, K_DIN);
      8'h60, 8'hC7, 8'hB0, 8'hD0, 8'h06, 8'h04, 8'hB9, 8'hAB: r = sfcf_mk(1'b0, 2'h0, K_NONE);
      8'h05, 8'h9F: r = sfcf_mk(1'b0, 2'h0, K_OUT);
      8'h01, 8'h31, 8'hF0: r = sfcf_mk(1'b0, 2'h0, K_IN);
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction
endpackage

// File: hdl/sfcf_link_if.sv
// serial link between host and device ends, with pin resolution
`timescale 1ns/1ps
`default_nettype none
interface sfcf_link_if;
  logic cs_n; // chip select, active low
  logic sck; // serial clock
  logic host_odp; // host drive onto dual_out_data_pin
  logic host_odp_oe_n; // host enable, active low
  logic host_idp; // host drive onto dual_in_data_pin
  logic host_idp_oe_n; // host enable, active low
  logic dev_odp; // device drive onto dual_out_data_pin
  logic dev_odp_oe_n; // device enable, active low
  logic dev_idp; // device drive onto dual_in_data_pin
  logic dev_idp_oe_n; // device enable, active low
  logic dual_out_data_pin; // resolved host-to-device line
  logic dual_in_data_pin; // resolved device-to-host line

  // undriven lines float high, as with a weak pull-up
  assign dual_out_data_pin = !dev_odp_oe_n ? dev_odp : (!host_odp_oe_n ? host_odp : 1'b1);
  assign dual_in_data_pin = !dev_idp_oe_n ? dev_idp : (!host_idp_oe_n ? host_idp : 1'b1);

  modport host (
    output cs_n, sck, host_odp, host_odp_oe_n, host_idp, host_idp_oe_n,
    input dual_out_data_pin, dual_in_data_pin
  );
  modport device (
    input cs_n, sck, dual_out_data_pin, dual_in_data_pin,
    output dev_odp, dev_odp_oe_n, dev_idp, dev_idp_oe_n
  );
endinterface
`default_nettype wire

// File: hdl/sfcf_device.sv
// device end: command framing on the serial clock, hand-off to the core clock
// Notes on behaviour
// [R1] - first eight bits after select are opcode
// [R2] - every byte travels most significant bit first
// [R3] - deselect ends the current command
// [R4] - unknown opcode: ignore input until reselect
// [R5] - early deselect: nothing done, back to idle
// [R6] - host sends three address bytes, top first
// [R7] - top three address bits are dropped
// [R8] - clock may idle low or high
// [R9] - sample on rising edge, drive on falling
// [R10] - dual program: output pin becomes second input
// [R11] - dual read: input pin becomes second output
// [R12] - reading wraps from last byte to zero
// [R13] - pins float when deselected or not reading
`timescale 1ns/1ps
`default_nettype none
module sfcf_device #(
  parameter int AW = sfcf_pkg::ARRAY_AW // decoded address width
) (
  input wire logic core_clk_i, // core clock
  input wire logic arst_n_i, // async reset, active low
  sfcf_link_if.device link, // serial link, device side
  output logic cmd_valid_o, // pulse: command header complete
  output logic [sfcf_pkg::BYTE_W-1:0] cmd_opcode_o, // opcode of that command
  output logic [AW-1:0] cmd_addr_o, // address of that command
  output logic wr_valid_o, // pulse: one data byte received
  output logic [sfcf_pkg::BYTE_W-1:0] wr_data_o, // received data byte
  output logic rd_req_o, // pulse: supply byte at rd_addr_o
  output logic [AW-1:0] rd_addr_o, // array address to read
  input wire logic [sfcf_pkg::BYTE_W-1:0] rd_data_i, // byte taken in the rd_req_o cycle
  output logic frame_end_o // pulse: chip select released
);
  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (AW < 2 || AW > sfcf_pkg::LINK_AW) begin : g_bad_aw
    $error("sfcf_device: AW out of range");
  end

  localparam int BW = sfcf_pkg::BYTE_W;

  function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
    return a + {{(AW-1){1'b0}}, 1'b1};
  endfunction

  // ****************************************************************
  // link side declarations
  // ****************************************************************
  sfcf_pkg::sfcf_dev_state_e st_reg, st_next, data_st;
  sfcf_pkg::sfcf_op_s info;
  logic link_clr;
  logic [BW-1:0] sr_reg, sr_next, op_now;
  logic [2:0] bit_reg, bit_next, step, out_cnt_reg, ostep;
  logic [1:0] byte_reg;
  logic dual_in, dual_kind, byte_done, opc_done, addr_done, dummy_done;
  logic hdr_done, start_out, fetch;
  logic [BW-1:0] hand_op_reg, wr_byte_reg, out_sr_reg;
  logic [AW-1:0] hand_addr_reg, addr_shift, addr_now, rd_addr_reg;
  logic cmd_tgl_reg, wr_tgl_reg, fetch_tgl_reg;
  logic idp_oe_n_reg, odp_oe_n_reg;
  logic [BW-1:0] rd_hold_reg;

  // deselect clears the frame, so a half-sent header leaves no trace
  assign link_clr = link.cs_n | ~arst_n_i; // [R3] [R5]

  // ****************************************************************
  // bit sampling and header decode
  // ****************************************************************
  assign dual_in = (st_reg == sfcf_pkg::DS_DIN) && (info.kind == sfcf_pkg::K_DIN);
  assign dual_kind = (info.kind == sfcf_pkg::K_DOUT);
  assign step = (dual_in || (st_reg == sfcf_pkg::DS_DOUT && dual_kind)) ?
    sfcf_pkg::STEP_TWO : sfcf_pkg::STEP_ONE;
  // dual program takes two bits a clock, output pin carrying the higher
  assign sr_next = dual_in ? {sr_reg[BW-3:0], link.dual_in_data_pin, link.dual_out_data_pin}
    : {sr_reg[BW-2:0], link.dual_out_data_pin}; // [R2] [R10]
  assign bit_next = bit_reg + step;
  assign byte_done = (bit_next == 3'h0);
  assign op_now = (st_reg == sfcf_pkg::DS_OPC) ? sr_next : hand_op_reg;
  assign info = sfcf_pkg::sfcf_decode(op_now);
  assign opc_done = (st_reg == sfcf_pkg::DS_OPC) && byte_done; // [R1]
  assign addr_done = (st_reg == sfcf_pkg::DS_ADDR) && byte_done
    && (byte_reg == sfcf_pkg::ADDR_LAST); // [R6]
  assign dummy_done = (st_reg == sfcf_pkg::DS_DUMMY) && byte_done
    && ((byte_reg + 2'h1) == info.dummy);
  assign hdr_done = (opc_done && info.valid && !info.has_addr) || addr_done;
  // only the low address bits are kept; the top ones fall off the shifter
  assign addr_shift = {hand_addr_reg[AW-2:0], link.dual_out_data_pin}; // [R7]
  assign addr_now = (st_reg == sfcf_pkg::DS_ADDR) ? addr_shift :
    ((st_reg == sfcf_pkg::DS_OPC) ? '0 : hand_addr_reg);
  assign data_st = (info.kind == sfcf_pkg::K_IN || info.kind == sfcf_pkg::K_DIN) ?
    sfcf_pkg::DS_DIN : ((info.kind == sfcf_pkg::K_OUT || dual_kind) ?
    sfcf_pkg::DS_DOUT : sfcf_pkg::DS_IGNORE);
  assign start_out = (st_next == sfcf_pkg::DS_DOUT) && (st_reg != sfcf_pkg::DS_DOUT);
  // next byte is fetched as the current one starts, a full byte ahead
  assign fetch = start_out || (st_reg == sfcf_pkg::DS_DOUT && bit_reg == 3'h0);

  // frame sequencing
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      sfcf_pkg::DS_OPC: begin
        if (byte_done) begin
          if (!info.valid) begin
            st_next = sfcf_pkg::DS_IGNORE; // [R4]
          end else if (info.has_addr) begin
            st_next = sfcf_pkg::DS_ADDR;
          end else begin
            st_next = data_st;
          end
        end
      end
      sfcf_pkg::DS_ADDR: begin
        if (addr_done) begin
          st_next = (info.dummy != 2'h0) ? sfcf_pkg::DS_DUMMY : data_st;
        end
      end
      sfcf_pkg::DS_DUMMY: begin
        if (dummy_done) begin
          st_next = data_st;
        end
      end
      default: st_next = st_reg; // ignore and data states hold to deselect
    endcase
  end

  // ****************************************************************
  // rising edge logic; frame state cleared by deselect, hand-off words by reset only
  // ****************************************************************
  // no clock polarity is assumed: only rising edges move the frame
  always_ff @(posedge link.sck or posedge link_clr) begin // [R8] [R9]
    if (link_clr) begin
      st_reg <= sfcf_pkg::DS_OPC;
      sr_reg <= '0;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      sr_reg <= sr_next;
      bit_reg <= bit_next;
      byte_reg <= (st_next != st_reg) ? 2'h0 : (byte_reg + {1'b0, byte_done});
    end
  end

  // hand-off words survive deselect so the core can still pick them up
  always_ff @(posedge link.sck or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hand_op_reg <= '0;
      hand_addr_reg <= '0;
      wr_byte_reg <= '0;
      rd_addr_reg <= '0;
      cmd_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
      fetch_tgl_reg <= 1'b0;
    end else begin
      if (opc_done) begin
        hand_op_reg <= sr_next;
      end
      if (opc_done || st_reg == sfcf_pkg::DS_ADDR) begin
        hand_addr_reg <= opc_done ? '0 : addr_shift;
      end
      if (hdr_done) begin
        cmd_tgl_reg <= ~cmd_tgl_reg;
      end
      if (st_reg == sfcf_pkg::DS_DIN && byte_done) begin
        wr_byte_reg <= sr_next;
        wr_tgl_reg <= ~wr_tgl_reg;
      end
      if (fetch) begin
        rd_addr_reg <= start_out ? addr_now : addr_inc(rd_addr_reg); // [R12]
        fetch_tgl_reg <= ~fetch_tgl_reg;
      end
    end
  end

  // ****************************************************************
  // falling edge output
  // ****************************************************************
  assign ostep = dual_kind ? sfcf_pkg::STEP_TWO : sfcf_pkg::STEP_ONE;

  // rd_hold_reg is settled well before this edge by the fetch handshake
  always_ff @(negedge link.sck or posedge link_clr) begin // [R9]
    if (link_clr) begin
      out_sr_reg <= '0;
      out_cnt_reg <= 3'h0;
      idp_oe_n_reg <= 1'b1; // [R13]
      odp_oe_n_reg <= 1'b1;
    end else if (st_reg == sfcf_pkg::DS_DOUT) begin
      idp_oe_n_reg <= 1'b0;
      odp_oe_n_reg <= ~dual_kind; // [R11]
      out_cnt_reg <= out_cnt_reg + ostep;
      out_sr_reg <= (out_cnt_reg == 3'h0) ? rd_hold_reg : (out_sr_reg << ostep); // [R2]
    end
  end

  assign link.dev_idp = out_sr_reg[BW-1];
  assign link.dev_odp = out_sr_reg[BW-2];
  assign link.dev_idp_oe_n = idp_oe_n_reg; // [R13]
  assign link.dev_odp_oe_n = odp_oe_n_reg;

  // ****************************************************************
  // core clock side
  // ****************************************************************
  logic [2:0] tgl_s1_reg, tgl_s2_reg, tgl_s3_reg, tgl_ev;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;

  assign tgl_ev = tgl_s2_reg ^ tgl_s3_reg;

  // toggles cross on two flops; words beside them are stable by then
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tgl_s1_reg <= 3'h0;
      tgl_s2_reg <= 3'h0;
      tgl_s3_reg <= 3'h0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      cmd_valid_o <= 1'b0;
      cmd_opcode_o <= '0;
      cmd_addr_o <= '0;
      wr_valid_o <= 1'b0;
      wr_data_o <= '0;
      rd_req_o <= 1'b0;
      rd_addr_o <= '0;
      rd_hold_reg <= '0;
      frame_end_o <= 1'b0;
    end else begin
      tgl_s1_reg <= {fetch_tgl_reg, wr_tgl_reg, cmd_tgl_reg};
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      cmd_valid_o <= tgl_ev[0];
      wr_valid_o <= tgl_ev[1];
      rd_req_o <= tgl_ev[2];
      frame_end_o <= cs_s2_reg & ~cs_s3_reg; // [R3]
      if (tgl_ev[0]) begin
        cmd_opcode_o <= hand_op_reg;
        cmd_addr_o <= hand_addr_reg;
      end
      if (tgl_ev[1]) begin
        wr_data_o <= wr_byte_reg;
      end
      if (tgl_ev[2]) begin
        rd_addr_o <= rd_addr_reg;
      end
      if (rd_req_o) begin
        rd_hold_reg <= rd_data_i;
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/sfcf_host.sv
// host end: frames one command per request and drives the serial clock
`timescale 1ns/1ps
`default_nettype none
module sfcf_host #(
  parameter int HALF_CYC = 4, // core cycles per serial clock half
  parameter bit CPOL = 1'b0, // idle clock level: 0 mode 0, 1 mode 3
  parameter int LEN_W = 16 // width of the data byte count
) (
  input wire logic core_clk_i, // core clock
  input wire logic arst_n_i, // async reset, active low
  sfcf_link_if.host link, // serial link, host side
  input wire logic start_i, // pulse: start one command
  input wire logic [sfcf_pkg::BYTE_W-1:0] opcode_i, // opcode to send
  input wire logic [sfcf_pkg::LINK_AW-1:0] addr_i, // 24-bit address
  input wire logic [LEN_W-1:0] len_i, // data phase bytes
  input wire logic [sfcf_pkg::BYTE_W-1:0] wdata_i, // next write byte
  output logic wdata_take_o, // pulse: wdata_i was consumed
  output logic [sfcf_pkg::BYTE_W-1:0] rdata_o, // last read byte
  output logic rdata_valid_o, // pulse: rdata_o new
  output logic busy_o // high while a command runs
);
  // ****************************************************************
  // parameter check and declarations
  // ****************************************************************
  if (HALF_CYC < 2 || HALF_CYC > 256 || LEN_W < 2 || LEN_W > 24) begin : g_bad
    $error("sfcf_host: parameter out of range");
  end

  localparam int BW = sfcf_pkg::BYTE_W;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  function automatic logic [2:0] hdr_bytes(input sfcf_pkg::sfcf_op_s i);
    return 3'h1 + (i.has_addr ? sfcf_pkg::ADDR_HDR : 3'h0) + {1'b0, i.dummy};
  endfunction

  sfcf_pkg::sfcf_host_state_e st_reg;
  sfcf_pkg::sfcf_op_s info, info_in;
  logic [7:0] half_reg;
  logic sck_reg, cs_n_reg;
  logic [BW-1:0] sr_reg, sr_next, op_reg, next_byte;
  logic [sfcf_pkg::LINK_AW-1:0] addr_reg;
  logic [2:0] bit_reg, bit_next;
  logic [LEN_W:0] idx_reg, last_reg, idx_inc;
  logic [1:0] pin_s1_reg, pin_s2_reg;
  logic half_end, data_ph, next_data, dual, is_rd, is_wr, byte_end;

  // ****************************************************************
  // byte sequencing
  // ****************************************************************
  assign info = sfcf_pkg::sfcf_decode(op_reg);
  assign info_in = sfcf_pkg::sfcf_decode(opcode_i);
  assign half_end = (half_reg == HALF_LAST);
  assign idx_inc = idx_reg + {{LEN_W{1'b0}}, 1'b1};
  assign data_ph = idx_reg >= {{(LEN_W-2){1'b0}}, hdr_bytes(info)};
  assign next_data = idx_inc >= {{(LEN_W-2){1'b0}}, hdr_bytes(info)};
  assign is_rd = (info.kind == sfcf_pkg::K_OUT || info.kind == sfcf_pkg::K_DOUT);
  assign is_wr = (info.kind == sfcf_pkg::K_IN || info.kind == sfcf_pkg::K_DIN);
  assign dual = (st_reg == sfcf_pkg::HS_RUN) && data_ph
    && (info.kind == sfcf_pkg::K_DIN || info.kind == sfcf_pkg::K_DOUT);
  assign bit_next = bit_reg + (dual ? sfcf_pkg::STEP_TWO : sfcf_pkg::STEP_ONE);
  assign byte_end = (bit_next == 3'h0);
  // sampled at the end of the high half, well after the device's falling edge
  assign sr_next = dual ? {sr_reg[BW-3:0], pin_s2_reg} : {sr_reg[BW-2:0], pin_s2_reg[1]};
  // address bytes go top first; dummy bytes are zero
  assign next_byte = (info.has_addr && idx_inc == (LEN_W+1)'(1)) ? addr_reg[23:16] :
    (info.has_addr && idx_inc == (LEN_W+1)'(2)) ? addr_reg[15:8] :
    (info.has_addr && idx_inc == (LEN_W+1)'(3)) ? addr_reg[7:0] :
    (next_data && is_wr) ? wdata_i : '0;

  // ****************************************************************
  // link pins
  // ****************************************************************
  assign link.cs_n = cs_n_reg;
  assign link.sck = sck_reg;
  assign link.host_odp = dual ? sr_reg[BW-2] : sr_reg[BW-1];
  assign link.host_idp = sr_reg[BW-1];
  // stay off the line until select rises: the device drives it up to then
  assign link.host_odp_oe_n = (dual || st_reg == sfcf_pkg::HS_GAP)
    && (info.kind == sfcf_pkg::K_DOUT);
  assign link.host_idp_oe_n = !(dual && (info.kind == sfcf_pkg::K_DIN));
  assign busy_o = (st_reg != sfcf_pkg::HS_IDLE);

  // ****************************************************************
  // main sequencer
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= sfcf_pkg::HS_IDLE;
      half_reg <= 8'h00;
      sck_reg <= CPOL;
      cs_n_reg <= 1'b1;
      sr_reg <= '0;
      op_reg <= '0;
      addr_reg <= '0;
      bit_reg <= 3'h0;
      idx_reg <= '0;
      last_reg <= '0;
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      wdata_take_o <= 1'b0;
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      pin_s1_reg <= {link.dual_in_data_pin, link.dual_out_data_pin};
      pin_s2_reg <= pin_s1_reg;
      wdata_take_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      half_reg <= half_end ? 8'h00 : (half_reg + 8'h01);
      case (st_reg)
        sfcf_pkg::HS_IDLE: begin
          half_reg <= 8'h00;
          if (start_i) begin
            st_reg <= sfcf_pkg::HS_RUN;
            cs_n_reg <= 1'b0;
            sck_reg <= 1'b0;
            sr_reg <= opcode_i;
            op_reg <= opcode_i;
            addr_reg <= addr_i;
            bit_reg <= 3'h0;
            idx_reg <= '0;
            last_reg <= {{(LEN_W-2){1'b0}}, hdr_bytes(info_in)} + {1'b0, len_i}
              - {{LEN_W{1'b0}}, 1'b1};
          end
        end
        sfcf_pkg::HS_RUN: begin
          if (half_end && !sck_reg) begin
            sck_reg <= 1'b1;
          end else if (half_end) begin
            bit_reg <= bit_next;
            sr_reg <= sr_next;
            sck_reg <= 1'b0;
            if (byte_end) begin
              if (data_ph && is_rd) begin
                rdata_o <= sr_next;
                rdata_valid_o <= 1'b1;
              end
              if (idx_reg == last_reg) begin
                st_reg <= sfcf_pkg::HS_GAP;
                sck_reg <= CPOL; // mode 3 stays high, no extra edge
              end else begin
                idx_reg <= idx_inc;
                sr_reg <= next_byte;
                wdata_take_o <= next_data && is_wr;
              end
            end
          end
        end
        sfcf_pkg::HS_GAP: begin
          if (half_end && !cs_n_reg) begin
            cs_n_reg <= 1'b1;
          end else if (half_end) begin
            st_reg <= sfcf_pkg::HS_IDLE;
          end
        end
        default: st_reg <= sfcf_pkg::HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verification/sfcf_monitor.sv
// checker for the serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module sfcf_monitor (
  input wire logic core_clk_i, // core clock
  input wire logic arst_n_i, // reset, active low
  input wire logic cs_n, // chip select
  input wire logic sck, // serial clock
  input wire logic host_idp_oe_n, // host enable, low drives
  input wire logic host_odp_oe_n, // host enable on other line, low drives
  input wire logic dev_idp, // device bit on dual_in_data_pin
  input wire logic dev_idp_oe_n, // device enable, low drives
  input wire logic dev_odp, // device bit on dual_out_data_pin
  input wire logic dev_odp_oe_n // device enable, low drives
);
  // ***
  // rising clock edges counted per frame
  // ***
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic sck_reg;
  logic [15:0] rise_reg;
  wire logic [15:0] rise_next;
  // core rate is fast enough: every serial half spans several core cycles
  assign rise_next = cs_n ? 16'h0000 : rise_reg + {15'h0000, sck & ~sck_reg};
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_reg <= 1'b0;
      rise_reg <= 16'h0000;
    end else begin
      sck_reg <= sck;
      rise_reg <= rise_next;
    end
  end
  // link assertions
  property p_idle_clk; cs_n && $past(cs_n) |-> $stable(sck); endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock moved while idle");
  property p_oe_sel; (!dev_idp_oe_n || !dev_odp_oe_n) |-> !cs_n; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("drive while deselected");
  property p_oe_fall; $fell(dev_idp_oe_n) |-> $fell(sck); endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive began off edge");
  property p_bit_fall;
    !dev_idp_oe_n && $past(!dev_idp_oe_n) &&
      ($changed(dev_idp) || (!dev_odp_oe_n && $past(!dev_odp_oe_n) && $changed(dev_odp)))
      |-> $fell(sck);
  endproperty
  a_bit_fall: assert property (p_bit_fall) else $error("bit changed off edge");
  property p_dual_pair; !dev_odp_oe_n |-> !dev_idp_oe_n; endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("lane without partner");
  property p_no_fight; !host_idp_oe_n |-> dev_idp_oe_n; endproperty
  a_no_fight: assert property (p_no_fight) else $error("pin driven twice");
  property p_no_fight_si; !dev_odp_oe_n |-> host_odp_oe_n; endproperty
  a_no_fight_si: assert property (p_no_fight_si) else $error("line driven twice");
  property p_whole; $rose(cs_n) |-> rise_reg[2:0] == 3'h0; endproperty
  a_whole: assert property (p_whole) else $error("partial byte in frame");
  property p_late; $fell(dev_idp_oe_n) |-> rise_reg >= 16'h0008; endproperty
  a_late: assert property (p_late) else $error("drive before opcode");
  c_dual_read: cover property (!dev_odp_oe_n);
  c_dual_prog: cover property (!host_idp_oe_n);
  c_long: cover property ($rose(cs_n) && rise_reg >= 16'h0030);
endmodule
`default_nettype wire

// File: verification/testbench.sv
// bench: host and device ends joined over the link, driven from the user sides
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ***
  // stimulus, ends and event capture
  // ***
  logic core_clk = 1'b0;
  logic arst_n = 1'b1;
  logic hrst_n = 1'b1;
  logic start = 1'b0;
  logic [7:0] opc = 8'h00;
  logic [23:0] adr = 24'h000000;
  logic [15:0] len = 16'h0000;
  logic [7:0] wcnt = 8'h00;
  logic take, rvld, busy, cvld, wvld, rreq, fend;
  logic [7:0] rdat, copc, wdat, rdd, wbyte;
  logic [20:0] caddr, raddr;
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  int err_count = 0;
  int total_checks = 0;
  int n_cmd = 0;
  int n_end = 0;
  // array stand-in: byte follows its address, so a wrong wrap shows up
  assign rdd = raddr[7:0] ^ 8'h5A;
  assign wbyte = 8'hC3 ^ wcnt;
  always #4 core_clk = ~core_clk;
  sfcf_link_if sfcf_link_if_inst ();
  sfcf_host #(.HALF_CYC(10)) sfcf_host_inst (.core_clk_i(core_clk), .arst_n_i(arst_n & hrst_n),
    .link(sfcf_link_if_inst.host), .start_i(start), .opcode_i(opc), .addr_i(adr), .len_i(len),
    .wdata_i(wbyte), .wdata_take_o(take), .rdata_o(rdat), .rdata_valid_o(rvld), .busy_o(busy));
  sfcf_device sfcf_device_inst (.core_clk_i(core_clk), .arst_n_i(arst_n),
    .link(sfcf_link_if_inst.device), .cmd_valid_o(cvld), .cmd_opcode_o(copc),
    .cmd_addr_o(caddr), .wr_valid_o(wvld), .wr_data_o(wdat), .rd_req_o(rreq),
    .rd_addr_o(raddr), .rd_data_i(rdd), .frame_end_o(fend));
  sfcf_monitor sfcf_monitor_inst (.core_clk_i(core_clk), .arst_n_i(arst_n),
    .cs_n(sfcf_link_if_inst.cs_n), .sck(sfcf_link_if_inst.sck),
    .host_idp_oe_n(sfcf_link_if_inst.host_idp_oe_n),
    .host_odp_oe_n(sfcf_link_if_inst.host_odp_oe_n), .dev_idp(sfcf_link_if_inst.dev_idp),
    .dev_idp_oe_n(sfcf_link_if_inst.dev_idp_oe_n), .dev_odp(sfcf_link_if_inst.dev_odp),
    .dev_odp_oe_n(sfcf_link_if_inst.dev_odp_oe_n));
  // pulses last one cycle, so each is counted once
  always @(posedge core_clk) begin
    if (cvld === 1'b1) n_cmd++;
    if (fend === 1'b1) n_end++;
    if (wvld === 1'b1) wq.push_back(wdat);
    if (rvld === 1'b1) rq.push_back(rdat);
    if (take === 1'b1) wcnt <= wcnt + 8'h01;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask
  // one whole frame; a hung host ends the run
  task automatic run(input logic [7:0] o, input logic [23:0] a, input logic [15:0] l);
    int i;
    n_cmd = 0;
    n_end = 0;
    wcnt = 8'h00;
    rq.delete();
    wq.delete();
    opc = o;
    adr = a;
    len = l;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    for (i = 0; i < 9000 && busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 9000) begin
      check(busy, 1'b0);
      stop_test();
    end
    repeat (12) @(posedge core_clk);
    #1;
    check(n_end, 1);
  endtask
  // every read kind straddles the top of the array
  task automatic t_read();
    logic [7:0] ops [4] = '{8'h03, 8'h0B, 8'h1B, 8'h3B};
    foreach (ops[k]) begin
      run(ops[k], 24'hFFFFFF, 16'h0002);
      check(copc, ops[k]);
      check(caddr, 21'h1FFFFF);
      check(rq.size(), 2);
      check({rq[0], rq[1]}, {8'hA5, 8'h5A});
    end
    $display("read test done");
  endtask
  // single and dual program with the dropped address bits set
  task automatic t_prog();
    logic [7:0] ops [2] = '{8'h02, 8'hA2};
    foreach (ops[k]) begin
      run(ops[k], 24'hFABCDE, 16'h0002);
      check(n_cmd, 1);
      check(caddr, 21'h1ABCDE);
      check(wq.size(), 2);
      check({wq[0], wq[1]}, {8'hC3, 8'hC2});
    end
    $display("program test done");
  endtask
  // unknown opcode ignored for its frame, the next frame works
  task automatic t_bad();
    run(8'hFF, 24'h000000, 16'h0002);
    check(n_cmd, 0);
    check(wq.size() + rq.size(), 0);
    run(8'h20, 24'h200000, 16'h0000);
    check(n_cmd, 1);
    check(caddr, 21'h000000);
    $display("bad opcode test done");
  endtask
  // host reset drops select after opcode and one address byte; next frame still works
  task automatic t_cut();
    n_cmd = 0;
    n_end = 0;
    opc = 8'h02;
    adr = 24'h012345;
    len = 16'h0001;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    repeat (320) @(posedge core_clk); // sixteen serial clocks, twenty cycles each
    #1 hrst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 hrst_n = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    check(n_cmd, 0);
    check(n_end, 1);
    run(8'h05, 24'h000000, 16'h0002);
    check(n_cmd, 1);
    check({rq[0], rq[1]}, {8'h5A, 8'h5B});
    $display("cut test done");
  endtask
  initial begin
    // a real falling edge, so the select-cleared link logic starts known
    #1 arst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    t_read();
    t_prog();
    t_bad();
    t_cut();
    stop_test();
  end
endmodule
`default_nettype wire
